//--- include/reset_cause_pkg.sv
// Constants, register map and field layout for the reset cause logic
// What this block does
// RL1 - Reset instruction resets, keeps clock source
// RL2 - Release system reset next instruction cycle
// RL3 - Reset instruction sets soft flag bit 6
// RL4 - Watchdog timeout resets asynchronously, clock kept
// RL5 - Watchdog timeout in sleep/idle only wakes
// RL6 - Watchdog reset sets flag bit 4
// RL7 - Lower hard trap during higher trap resets
// RL8 - Hard traps are levels 13 to 15
// RL9 - Trap conflict sets flag bit 15
// RL10 - Shadow mismatch of pin-select triggers reset
// RL11 - Mismatch reset sets flag bit 9
// RL12 - Illegal conditions share flag bit 14
// RL13 - Illegal opcode execution resets device
// RL14 - Constant data upper byte holds illegal opcode
// RL15 - External pin reset sets pin flag
// RL16 - Flags survive reset until software clears
package reset_cause_pkg;
	// Byte addresses on APB
	localparam logic [11:0] CAUSE_ADDR  = 12'h000;  // Reset cause register
	localparam logic [11:0] MASK_ADDR   = 12'h004;  // Interrupt mask
	localparam logic [11:0] CTRL_ADDR   = 12'h008;  // Control: shadow check enable
	localparam logic [11:0] STATE_ADDR  = 12'h00C;  // Live state view
	// Cause register bit positions
	localparam int PIN_BIT     = 7;
	localparam int SOFT_BIT    = 6;
	localparam int WDOG_BIT    = 4;
	localparam int MISM_BIT    = 9;
	localparam int ILLEGAL_BIT = 14;
	localparam int TRAP_BIT    = 15;
	localparam logic [15:0] CAUSE_IMPL = 16'hC2D0;  // Implemented flag bits
	localparam logic [15:0] CAUSE_RST  = 16'h0000;
	localparam logic [15:0] MASK_RST   = 16'h0000;
	localparam logic        CHECK_RST  = 1'b1;     // Shadow checking on after reset
	// Hard trap levels
	localparam logic [3:0] HARD_LO   = 4'hD;
	localparam logic [3:0] HARD_HI   = 4'hF;
	// System reset hold: one instruction cycle of core clocks
	localparam int INSTR_CYCLE_CLKS = 2;
	localparam logic [1:0] HOLD_LAST = 2'(INSTR_CYCLE_CLKS - 1);
	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_RUN  = 2'h1,
		ST_HOLD = 2'h2
	} seq_state_type;
	function automatic logic is_hard(input logic [3:0] lvl);
		return (lvl >= HARD_LO) && (lvl <= HARD_HI);
	endfunction
endpackage

//--- design/trap_conflict_detect.sv
// Detector of a lower priority hard trap during a higher one
`timescale 1ns/1ps
`default_nettype none
module trap_conflict_detect
	import reset_cause_pkg::*;
(
	input  wire logic       in_service_i,  // Higher trap being serviced
	input  wire logic [3:0] active_level_i, // Level of trap in service
	input  wire logic       trap_req_i,    // New trap request
	input  wire logic [3:0] trap_level_i,  // Level of new trap
	output logic            conflict_o     // Conflict found
);
	// A new hard trap below the serviced level forces a reset
	always_comb begin
		conflict_o = in_service_i && trap_req_i && is_hard(trap_level_i)  // see RL7 see RL8
			&& is_hard(active_level_i) && (trap_level_i < active_level_i);
	end
endmodule // trap_conflict_detect
`default_nettype wire

//--- design/reset_cause_logic.sv
// Reset cause sequencer with APB-visible cause flags
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_logic (
	input  wire logic        core_clk_i,        // System clock
	input  wire logic        reset_i,           // Power-on reset, sync high
	input  wire logic        master_reset_pin_n_i, // External reset pin, low active
	input  wire logic        reset_instr_i,     // Reset instruction executed
	input  wire logic        watchdog_timeout_i, // Watchdog time-out
	input  wire logic        sleep_i,           // Core in sleep
	input  wire logic        idle_i,            // Core in idle
	input  wire logic        in_service_i,      // Trap being serviced
	input  wire logic [3:0]  active_level_i,    // Level of serviced trap
	input  wire logic        trap_req_i,        // New trap request
	input  wire logic [3:0]  trap_level_i,      // New trap level
	input  wire logic        shadow_mismatch_i, // Pin-select shadow differs
	input  wire logic        illegal_opcode_i,  // Illegal opcode executed
	input  wire logic        uninit_w_i,        // Uninitialised W access
	input  wire logic        security_i,        // Security violation
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB enable
	input  wire logic        pwrite,            // APB direction
	input  wire logic [11:0] paddr,             // APB address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic             pready,            // APB ready
	output logic [31:0]      prdata,            // APB read data
	output logic             pslverr,           // APB error
	output logic             system_reset_o,    // Internal system reset
	output logic             clock_reinit_o,    // Clock system reinit request
	output logic             wake_o,            // Wake pulse to core
	output logic             irq_o              // Interrupt, level
);
	import reset_cause_pkg::*;

	// Whole state of the block
	typedef struct packed {
		seq_state_type state;
		logic [1:0]    hold;
		logic [15:0]   cause;
		logic [15:0]   mask;
		logic          check_en;
		logic          sys_rst;
		logic          wake;
		logic [31:0]   rdata;
		logic          err;
	} state_type;

	state_type st_reg;   // Registered state
	state_type st_next;  // Next state
	logic      conflict; // Trap conflict from detector
	logic      low_power; // Sleep or idle
	logic      wd_reset;  // Watchdog reset request
	logic      any_event; // Any reset source now
	logic [15:0] set_bits; // Flags set this cycle
	logic      access;    // APB access phase
	logic      mapped;    // Address decodes

	trap_conflict_detect u_trap (
		.in_service_i   (in_service_i),
		.active_level_i (active_level_i),
		.trap_req_i     (trap_req_i),
		.trap_level_i   (trap_level_i),
		.conflict_o     (conflict)
	);

	// Source qualification and flag set terms
	// Every source is a level seen at the edge; a pulse must span one edge
	always_comb begin
		// Sleep and idle both count as low power for the watchdog
		low_power = sleep_i | idle_i;
		wd_reset  = watchdog_timeout_i & ~low_power;  // see RL5
		set_bits  = '0;
		set_bits[SOFT_BIT]    = reset_instr_i;  // see RL3
		set_bits[WDOG_BIT]    = wd_reset;       // see RL6
		set_bits[TRAP_BIT]    = conflict;       // see RL9
		set_bits[MISM_BIT]    = shadow_mismatch_i & st_reg.check_en;  // see RL10 see RL11
		set_bits[ILLEGAL_BIT] = illegal_opcode_i | uninit_w_i | security_i;  // see RL12 see RL13
		set_bits[PIN_BIT]     = ~master_reset_pin_n_i;  // see RL15
		any_event = |set_bits;
		// Bus decode shared by the register file and the error response
		access    = psel & penable;
		mapped    = (paddr == CAUSE_ADDR) || (paddr == MASK_ADDR)
			|| (paddr == CTRL_ADDR) || (paddr == STATE_ADDR);
	end

	// Next-state logic
	// One process builds the whole next state so no field is left latched
	always_comb begin
		// Default: every field keeps its value
		st_next = st_reg;
		// Wake stands for one cycle after a low-power time-out
		st_next.wake = watchdog_timeout_i & low_power;  // see RL5
		// Flags: hardware set wins over software clear; system reset leaves them
		if (access && pwrite && paddr == CAUSE_ADDR) begin
			st_next.cause = st_reg.cause & ~pwdata[15:0];
		end
		st_next.cause = (st_next.cause | set_bits) & CAUSE_IMPL;  // see RL16
		// Mask write; unimplemented bits read back zero
		if (access && pwrite && paddr == MASK_ADDR) begin
			st_next.mask = pwdata[15:0] & CAUSE_IMPL;
		end
		// Control write; bit 0 turns shadow checking on or off
		if (access && pwrite && paddr == CTRL_ADDR) begin
			st_next.check_en = pwdata[0];
		end
		// Read data captured for the access phase
		st_next.err = 1'b0;
		if (psel && !penable) begin
			st_next.err = ~mapped;
			case (paddr)
				CAUSE_ADDR: st_next.rdata = {16'h0000, st_reg.cause};
				MASK_ADDR:  st_next.rdata = {16'h0000, st_reg.mask};
				CTRL_ADDR:  st_next.rdata = {31'h00000000, st_reg.check_en};
				STATE_ADDR: st_next.rdata = {28'h0000000, st_reg.hold, st_reg.sys_rst,
					low_power};
				default:    st_next.rdata = 32'h00000000;
			endcase
		end
		// Sequencer: hold reset for one instruction cycle then release
		case (st_reg.state)
			ST_RUN: begin
				// Any cause enters the hold; its flag was set above
				if (any_event) begin
					st_next.state   = ST_HOLD;
					st_next.hold    = '0;
					st_next.sys_rst = 1'b1;  // see RL1
				end
			end
			ST_HOLD: begin
				// A fresh event restarts the count, so reset spans the last cause
				if (any_event) begin
					st_next.hold = '0;
				end else if (st_reg.hold == HOLD_LAST) begin
					st_next.state   = ST_RUN;  // see RL2
					st_next.sys_rst = 1'b0;
				end else begin
					st_next.hold = st_reg.hold + 2'h1;
				end
			end
			default: begin
				// Illegal code: recover to run with reset released
				st_next.state   = ST_RUN;
				st_next.sys_rst = 1'b0;
			end
		endcase
	end

	// State register
	// Only power-on reset clears the flags; the system reset output does not
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_reg.state    <= ST_RUN;
			st_reg.hold     <= '0;
			st_reg.cause    <= CAUSE_RST;
			st_reg.mask     <= MASK_RST;
			st_reg.check_en <= CHECK_RST;
			st_reg.sys_rst  <= 1'b0;
			st_reg.wake     <= 1'b0;
			st_reg.rdata    <= '0;
			st_reg.err      <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs; watchdog reset bypasses the clock
	// The watchdog term is not registered, so reset reaches the core at once
	always_comb begin
		system_reset_o = st_reg.sys_rst | wd_reset;  // see RL4
		clock_reinit_o = 1'b0;  // Clock source kept for every cause here; see RL1 see RL4
		wake_o  = st_reg.wake;
		irq_o   = |(st_reg.cause & st_reg.mask);
		// Zero wait states: read data was captured at the setup edge
		pready  = 1'b1;
		prdata  = st_reg.rdata;
		pslverr = st_reg.err & access;
	end

	// Checks
	property p_soft_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		reset_instr_i |=> st_reg.cause[SOFT_BIT];
	endproperty
	a_soft_flag: assert property (p_soft_flag) else $error("soft flag not set"); // see RL3
	property p_wdog_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		(watchdog_timeout_i && !sleep_i && !idle_i) |-> system_reset_o ##1 st_reg.cause[WDOG_BIT];
	endproperty
	a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog reset missing"); // see RL4
	property p_wdog_sleep;
		@(posedge core_clk_i) disable iff (reset_i)
		(watchdog_timeout_i && sleep_i && !st_reg.sys_rst) |-> !system_reset_o ##1 wake_o;
	endproperty
	a_wdog_sleep: assert property (p_wdog_sleep) else $error("sleep timeout reset"); // see RL5
	property p_trap_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		conflict |=> st_reg.cause[TRAP_BIT] && system_reset_o;
	endproperty
	a_trap_flag: assert property (p_trap_flag) else $error("trap conflict lost"); // see RL9
	property p_mism_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		(shadow_mismatch_i && st_reg.check_en) |=> st_reg.cause[MISM_BIT];
	endproperty
	a_mism_flag: assert property (p_mism_flag) else $error("mismatch flag lost"); // see RL11
	property p_illegal_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		(illegal_opcode_i || uninit_w_i || security_i) |=> st_reg.cause[ILLEGAL_BIT];
	endproperty
	a_illegal_flag: assert property (p_illegal_flag) else $error("illegal flag lost"); // see RL12
	property p_pin_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		!master_reset_pin_n_i |=> st_reg.cause[PIN_BIT];
	endproperty
	a_pin_flag: assert property (p_pin_flag) else $error("pin flag lost"); // see RL15
	sequence s_lone_event;
		reset_instr_i && !st_reg.sys_rst ##1 !any_event [*2];
	endsequence
	property p_release;
		@(posedge core_clk_i) disable iff (reset_i)
		s_lone_event |=> !st_reg.sys_rst;
	endproperty
	a_release: assert property (p_release) else $error("reset not released"); // see RL2
	property p_sticky;
		@(posedge core_clk_i) disable iff (reset_i)
		(st_reg.cause[SOFT_BIT] && !(access && pwrite && paddr == CAUSE_ADDR))
			|=> st_reg.cause[SOFT_BIT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped"); // see RL16

	// Start of a reset from the run state
	sequence s_event_start;
		any_event && !st_reg.sys_rst;
	endsequence

	// Reset instruction enters reset and leaves the clock alone
	property p_soft_reset;
		@(posedge core_clk_i) disable iff (reset_i)
		(reset_instr_i && !st_reg.sys_rst) |=> st_reg.sys_rst && !clock_reinit_o;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset missing"); // see RL1

	// Reset stands through the whole instruction cycle after a lone event
	property p_hold_min;
		@(posedge core_clk_i) disable iff (reset_i)
		s_event_start ##1 !any_event |=> st_reg.sys_rst;
	endproperty
	a_hold_min: assert property (p_hold_min) else $error("reset released early"); // see RL2

	// Watchdog reset is also held by the sequencer after the time-out
	property p_wdog_held;
		@(posedge core_clk_i) disable iff (reset_i)
		(watchdog_timeout_i && !sleep_i && !idle_i) |=> st_reg.sys_rst;
	endproperty
	a_wdog_held: assert property (p_wdog_held) else $error("watchdog reset lost"); // see RL4

	// Time-out in idle only wakes the core
	property p_idle_wake;
		@(posedge core_clk_i) disable iff (reset_i)
		(watchdog_timeout_i && idle_i && !st_reg.sys_rst) |-> !system_reset_o ##1 wake_o;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle timeout reset"); // see RL5

	// Time-out in low power leaves the watchdog flag alone
	property p_sleep_no_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		(watchdog_timeout_i && (sleep_i || idle_i) && !st_reg.cause[WDOG_BIT])
			|=> !st_reg.cause[WDOG_BIT];
	endproperty
	a_sleep_no_flag: assert property (p_sleep_no_flag) else $error("sleep flag set"); // see RL5

	// Wake is a single cycle pulse
	property p_wake_once;
		@(posedge core_clk_i) disable iff (reset_i)
		(wake_o && !(watchdog_timeout_i && (sleep_i || idle_i))) |=> !wake_o;
	endproperty
	a_wake_once: assert property (p_wake_once) else $error("wake stuck"); // see RL5

	// A trap at or above the serviced level is no conflict
	property p_nested_ok;
		@(posedge core_clk_i) disable iff (reset_i)
		(in_service_i && trap_req_i && (trap_level_i >= active_level_i)) |-> !conflict;
	endproperty
	a_nested_ok: assert property (p_nested_ok) else $error("false conflict"); // see RL7

	// A conflict starts a system reset
	property p_trap_reset;
		@(posedge core_clk_i) disable iff (reset_i)
		conflict |=> st_reg.sys_rst;
	endproperty
	a_trap_reset: assert property (p_trap_reset) else $error("conflict no reset"); // see RL7

	// Only hard trap levels can conflict
	property p_soft_trap;
		@(posedge core_clk_i) disable iff (reset_i)
		(trap_req_i && !is_hard(trap_level_i)) |-> !conflict;
	endproperty
	a_soft_trap: assert property (p_soft_trap) else $error("soft trap conflict"); // see RL8

	// Shadow mismatch with checking on resets the device
	property p_mism_reset;
		@(posedge core_clk_i) disable iff (reset_i)
		(shadow_mismatch_i && st_reg.check_en) |=> st_reg.sys_rst;
	endproperty
	a_mism_reset: assert property (p_mism_reset) else $error("mismatch no reset"); // see RL10

	// With checking off a mismatch leaves its flag clear
	property p_mism_off;
		@(posedge core_clk_i) disable iff (reset_i)
		(shadow_mismatch_i && !st_reg.check_en && !st_reg.cause[MISM_BIT])
			|=> !st_reg.cause[MISM_BIT];
	endproperty
	a_mism_off: assert property (p_mism_off) else $error("mismatch when off"); // see RL10

	// Uninitialised register access shares the illegal flag
	property p_uninit_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		uninit_w_i |=> st_reg.cause[ILLEGAL_BIT] && st_reg.sys_rst;
	endproperty
	a_uninit_flag: assert property (p_uninit_flag) else $error("uninit lost"); // see RL12

	// Security violation shares the illegal flag
	property p_secure_flag;
		@(posedge core_clk_i) disable iff (reset_i)
		security_i |=> st_reg.cause[ILLEGAL_BIT] && st_reg.sys_rst;
	endproperty
	a_secure_flag: assert property (p_secure_flag) else $error("security lost"); // see RL12

	// Illegal opcode resets the device
	property p_opcode_reset;
		@(posedge core_clk_i) disable iff (reset_i)
		illegal_opcode_i |=> st_reg.sys_rst;
	endproperty
	a_opcode_reset: assert property (p_opcode_reset) else $error("opcode no reset"); // see RL13

	// Pin held low resets the device
	property p_pin_reset;
		@(posedge core_clk_i) disable iff (reset_i)
		!master_reset_pin_n_i |=> st_reg.sys_rst;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin no reset"); // see RL15

	// Writing a one clears a flag when no new event sets it
	property p_soft_clear;
		@(posedge core_clk_i) disable iff (reset_i)
		(access && pwrite && (paddr == CAUSE_ADDR) && pwdata[SOFT_BIT] && !reset_instr_i)
			|=> !st_reg.cause[SOFT_BIT];
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("flag not cleared"); // see RL16

	// Pin flag survives the system reset it caused
	property p_pin_kept;
		@(posedge core_clk_i) disable iff (reset_i)
		(st_reg.cause[PIN_BIT] && st_reg.sys_rst && !(access && pwrite))
			|=> st_reg.cause[PIN_BIT];
	endproperty
	a_pin_kept: assert property (p_pin_kept) else $error("pin flag dropped"); // see RL16
endmodule // reset_cause_logic
`default_nettype wire

//--- tb/core_side_model.sv
// Model of core, watchdog, trap logic and shadow monitor
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
	input  wire logic  core_clk_i, // System clock
	output logic       pin_n_o,    // Reset pin, low active
	output logic       instr_o,    // Reset instruction
	output logic       wdog_o,     // Watchdog time-out
	output logic       sleep_o,    // Sleep level
	output logic       idle_o,     // Idle level
	output logic       busy_o,     // Trap in service
	output logic [3:0] busy_lvl_o, // Level in service
	output logic       trap_o,     // New trap
	output logic [3:0] trap_lvl_o, // New trap level
	output logic [3:0] ill_o       // Security, W, opcode, mismatch
);
	// Constant data word padded so a stray fetch traps
	localparam logic [23:0] DATA_WORD = 24'h3F0042;
	// Quiet levels until a test asks for an event
	initial begin
		{instr_o, wdog_o, sleep_o, idle_o, busy_o, trap_o, ill_o} = '0;
		pin_n_o = 1'b1;
		busy_lvl_o = 4'h0;
		trap_lvl_o = 4'h0;
	end
	// One event for one clock; 8/9 time-out in sleep/idle, 10 nested trap
	task automatic fire(input int k);
		@(posedge core_clk_i);
		pin_n_o <= (k != 0);
		instr_o <= (k == 1);
		wdog_o <= (k == 2) || (k == 8) || (k == 9);
		sleep_o <= (k == 8);
		idle_o <= (k == 9);
		busy_o <= (k == 3) || (k == 10);
		trap_o <= (k == 3) || (k == 10);
		busy_lvl_o <= (k == 3) ? 4'hE : 4'hD;
		trap_lvl_o <= (k == 3) ? 4'hD : 4'hE;
		ill_o <= {k == 7, k == 6, (k == 5) && (DATA_WORD[23:16] == 8'h3F), k == 4};
		@(posedge core_clk_i);
		{instr_o, wdog_o, sleep_o, idle_o, busy_o, trap_o, ill_o} <= '0;
		pin_n_o <= 1'b1;
	endtask
endmodule // core_side_model
`default_nettype wire

//--- tb/test_reset_cause_logic.sv
// Self-checking bench for the reset cause logic
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_logic;
	import reset_cause_pkg::*;
	logic core_clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic pready, pslverr, slv, sys_rst, clk_re, wake, irq, pin_n, instr, wdog, slp, idl;
	logic busy, trap;
	logic [3:0] busy_lvl, trap_lvl, ill;
	int err_count = 0, n_checks = 0;
	int kinds[8] = '{0, 1, 2, 3, 4, 5, 6, 7};
	int bits[8] = '{PIN_BIT, SOFT_BIT, WDOG_BIT, TRAP_BIT, MISM_BIT, ILLEGAL_BIT, ILLEGAL_BIT,
		ILLEGAL_BIT};
	// 200 MHz clock
	always #2.5 core_clk_i = ~core_clk_i;
	core_side_model core_side_model_i (.core_clk_i(core_clk_i), .pin_n_o(pin_n), .instr_o(instr),
		.wdog_o(wdog), .sleep_o(slp), .idle_o(idl), .busy_o(busy), .busy_lvl_o(busy_lvl),
		.trap_o(trap), .trap_lvl_o(trap_lvl), .ill_o(ill));
	reset_cause_logic reset_cause_logic_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.master_reset_pin_n_i(pin_n), .reset_instr_i(instr), .watchdog_timeout_i(wdog),
		.sleep_i(slp), .idle_i(idl), .in_service_i(busy), .active_level_i(busy_lvl),
		.trap_req_i(trap), .trap_level_i(trap_lvl), .shadow_mismatch_i(ill[0]),
		.illegal_opcode_i(ill[1]), .uninit_w_i(ill[2]), .security_i(ill[3]), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .system_reset_o(sys_rst), .clock_reinit_o(clk_re),
		.wake_o(wake), .irq_o(irq));
	// One APB transfer; waits for pready, only the hang guard ends a wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_i);
		end while (pready !== 1'b1);
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk_i);
		reset_i <= 1'b0;
		apb(1'b0, CAUSE_ADDR, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, CTRL_ADDR, 32'h0);
		chk(q, 32'h1);
		// Every cause in turn; first one runs with the interrupt masked
		foreach (kinds[i]) begin
			// Watchdog reset must show before the next edge; others wait for it
			fork
				core_side_model_i.fire(kinds[i]);
				begin
					@(posedge core_clk_i);
					#1;
					chk(sys_rst, 32'(i == 2));
				end
			join
			#1;
			chk(sys_rst, 32'h1);
			chk(clk_re, 32'h0);
			repeat (3) @(posedge core_clk_i);
			#1;
			chk(sys_rst, 32'h0);
			apb(1'b0, CAUSE_ADDR, 32'h0);
			chk(q, 32'h1 << bits[i]);
			chk(irq, 32'(i > 0));
			apb(1'b1, CAUSE_ADDR, 32'h1 << bits[i]);
			apb(1'b0, CAUSE_ADDR, 32'h0);
			chk(q | 32'(irq), 32'h0);
			if (i == 0) begin
				apb(1'b1, MASK_ADDR, 32'hFFFF);
				apb(1'b0, MASK_ADDR, 32'h0);
				chk(q, 32'(CAUSE_IMPL));
			end
		end
		// Time-out while asleep or idle only wakes; nested trap is no conflict
		for (int k = 8; k <= 10; k++) begin
			core_side_model_i.fire(k);
			#1;
			chk({wake, sys_rst}, {k < 10, 1'b0});
		end
		apb(1'b1, CTRL_ADDR, 32'h0);
		core_side_model_i.fire(4);
		#1;
		chk(sys_rst, 32'h0);
		apb(1'b0, CAUSE_ADDR, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, STATE_ADDR, 32'h0);
		chk(q & 32'h3, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({slv, q}, {1'b1, 32'h0});
		test_done();
	end
	// Hang guard
	initial begin
		#20000;
		err_count++;
		test_done();
	end
endmodule // test_reset_cause_logic
`default_nettype wire
